// ---- bench/rlc_top_props.sv ----
`timescale 1ns/1ps
// ======================================================
// port-level properties of the ladder control block
module rlc_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic sleep_active,
  input wire logic port_read_bit,
  input wire logic pad_oe,
  input wire logic pad_out,
  input wire logic pad_in_detect_en,
  input wire logic pad_analog_connect,
  input wire logic ladder_enable,
  input wire logic [8:0] ladder_tap,
  input wire logic [3:0] source_select_onehot,
  input wire logic ladder_sleep_warn
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic ctl_wr;
  logic high_wr;
  logic [7:0] wd_r;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign ctl_wr = wr && paddr == rlc_pkg::ADDR_CONTROL;
  assign high_wr = wr && paddr == rlc_pkg::ADDR_CODE_HIGH;
  // last write byte, so a control write can be compared one cycle on
  always_ff @(posedge pclk) begin
    wd_r <= pwdata[7:0];
  end
  chk_pin_cutoff: assert property (
    pad_analog_connect |-> !pad_oe && !pad_out && !pad_in_detect_en)
    else $error("pin digital path active with reference out");
  chk_read_zero: assert property (
    pad_analog_connect |-> !port_read_bit)
    else $error("port bit not zero with reference out");
  chk_tap_hold: assert property (
    !high_wr |=> $stable(ladder_tap))
    else $error("ladder tap moved without high write");
  chk_enable_bit: assert property (
    ctl_wr |=> ladder_enable == wd_r[7])
    else $error("ladder enable differs from written bit");
  chk_pin_bit: assert property (
    ctl_wr |=> pad_analog_connect == wd_r[5])
    else $error("pin connect differs from written bit");
  chk_source_sel: assert property (
    ctl_wr |=> source_select_onehot == (4'h1 << wd_r[3:2]))
    else $error("source select differs from written field");
  chk_reset_clear: assert property (
    $rose(presetn) |-> !ladder_enable && ladder_tap == 9'h000
      && !pad_analog_connect)
    else $error("state not cleared after reset");
  chk_sleep_hold: assert property (
    sleep_active && !ctl_wr |=> $stable(ladder_enable)
      && $stable(source_select_onehot))
    else $error("control changed during sleep");
  chk_sleep_warn: assert property (
    ladder_sleep_warn == (sleep_active && ladder_enable))
    else $error("sleep warning wrong");
  cov_high_wr: cover property (high_wr);
  cov_pin_on: cover property (ctl_wr && pwdata[5]);
  cov_sleep_on: cover property (sleep_active && ladder_enable);
endmodule

// ---- bench/rlc_top_tb.sv ----
`timescale 1ns/1ps
module rlc_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb, source_select_onehot;
  logic sleep_active, port_out_data, port_out_en, port_read_bit, pad_in;
  logic pad_out, pad_oe, pad_in_detect_en, pad_analog_connect;
  logic ladder_enable, ladder_sleep_warn;
  logic [8:0] ladder_tap;
  int bad_count, samples_checked;
  localparam logic [7:0] CTL = rlc_pkg::ADDR_CONTROL;
  localparam logic [7:0] HI = rlc_pkg::ADDR_CODE_HIGH;
  localparam logic [7:0] LO = rlc_pkg::ADDR_CODE_LOW;
  localparam logic [7:0] ST = rlc_pkg::ADDR_STATUS;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;

  rlc_top rlc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_active(sleep_active), .port_out_data(port_out_data),
    .port_out_en(port_out_en), .port_read_bit(port_read_bit),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_in_detect_en(pad_in_detect_en),
    .pad_analog_connect(pad_analog_connect),
    .ladder_enable(ladder_enable), .ladder_tap(ladder_tap),
    .source_select_onehot(source_select_onehot),
    .ladder_sleep_warn(ladder_sleep_warn));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ======================================================
  // reporting and bus tasks
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge, leaves one idle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      bad_count++;
      results();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, ZERO);
    check(q, exp);
  endtask

  // ======================================================
  // main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = ZERO;
    pstrb = 4'hF;
    sleep_active = 1'b0;
    port_out_data = 1'b0;
    port_out_en = 1'b0;
    pad_in = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CTL, ZERO);
    rdc(HI, ZERO);
    check(32'({ladder_enable, ladder_tap}), ZERO);
    check(32'(pad_in_detect_en), ONE);
    $display("test reset done");
    wr(CTL, 32'h0000_00FF);
    rdc(CTL, 32'h0000_00EC);
    check(32'({ladder_enable, pad_analog_connect}), 32'h0000_0003);
    for (int s = 0; s < 4; s++) begin
      wr(CTL, 32'h0000_0080 | (s << 2));
      check(32'(source_select_onehot), ONE << s);
    end
    $display("test control done");
    wr(LO, 32'h0000_00FF);
    check(32'(ladder_tap), ZERO);
    rdc(LO, 32'h0000_0080);
    wr(HI, 32'h0000_00A5);
    check(32'(ladder_tap), 32'h0000_014B);
    rdc(HI, 32'h0000_00A5);
    wr(CTL, 32'h0000_00C0);
    wr(LO, 32'h0000_003C);
    check(32'(ladder_tap), 32'h0000_014B);
    wr(HI, 32'h0000_00FF);
    rdc(HI, ONE);
    rdc(LO, 32'h0000_003C);
    check(32'(ladder_tap), 32'h0000_013C);
    rdc(ST, 32'h0000_813C);
    wr(ST, ZERO);
    check(32'(err), ONE);
    $display("test code done");
    port_out_en <= 1'b1;
    port_out_data <= 1'b1;
    pad_in <= 1'b1;
    wr(CTL, 32'h0000_00A0);
    repeat (3) @(posedge pclk);
    check(32'(port_read_bit), ZERO);
    check(32'({pad_oe, pad_out, pad_in_detect_en}), ZERO);
    check(32'(pad_analog_connect), ONE);
    wr(CTL, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    q = 32'({pad_oe, pad_out, pad_in_detect_en, port_read_bit});
    check(q, 32'h0000_000F);
    $display("test pin done");
    sleep_active <= 1'b1;
    @(posedge pclk);
    check(32'(ladder_sleep_warn), ONE);
    repeat (4) @(posedge pclk);
    rdc(CTL, 32'h0000_0080);
    sleep_active <= 1'b0;
    $display("test sleep done");
    wr(8'h10, 32'h0000_00FF);
    check(32'(err), ONE);
    pstrb <= 4'h0;
    wr(CTL, 32'h0000_00FF);
    pstrb <= 4'hF;
    rdc(CTL, 32'h0000_0080);
    rdc(8'h10, ZERO);
    $display("test refused done");
    wr(HI, 32'h0000_0055);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'({ladder_enable, ladder_tap}), ZERO);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(HI, ZERO);
    $display("test second reset done");
    results();
  end
endmodule

bind rlc_top rlc_top_props rlc_top_props_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .sleep_active(sleep_active), .port_read_bit(port_read_bit),
  .pad_oe(pad_oe), .pad_out(pad_out),
  .pad_in_detect_en(pad_in_detect_en),
  .pad_analog_connect(pad_analog_connect),
  .ladder_enable(ladder_enable), .ladder_tap(ladder_tap),
  .source_select_onehot(source_select_onehot),
  .ladder_sleep_warn(ladder_sleep_warn));

// ---- hdl/rlc_code_regs.sv ----
`timescale 1ns/1ps

module rlc_code_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic right_just,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  output logic [7:0] code_high_r,
  output logic [7:0] code_low_r,
  output logic [8:0] ladder_code_r
);

  logic [7:0] high_nxt;
  logic [7:0] low_nxt;

  // unused positions drop the written value under the current layout
  assign high_nxt = wdata & rlc_pkg::rlc_high_mask(right_just);
  assign low_nxt = wdata & rlc_pkg::rlc_low_mask(right_just);

  // ==========================================================
  // software-visible code pair
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_high_r <= rlc_pkg::CODE_RESET;
    end else if (wr_high) begin
      code_high_r <= high_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_low_r <= rlc_pkg::CODE_RESET;
    end else if (wr_low) begin
      code_low_r <= low_nxt;
    end
  end

  // ==========================================================
  // active ladder buffer
  // ==========================================================
  // only a high-half write moves the pair into the ladder, so a
  // low-half write alone never glitches the output level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ladder_code_r <= rlc_pkg::LADDER_RESET;
    end else if (wr_high) begin
      ladder_code_r <= rlc_pkg::rlc_assemble(right_just, high_nxt,
                                             code_low_r);
    end
  end

endmodule

// ---- hdl/rlc_pkg.sv ----
package rlc_pkg;

  // ==========================================================
  // widths and register map
  // ==========================================================
  localparam int unsigned REG_W = 8;
  localparam int unsigned CODE_W = 9;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CODE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CODE_LOW = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ==========================================================
  // control register fields
  // ==========================================================
  localparam int unsigned CTL_ENABLE_BIT = 7;
  localparam int unsigned CTL_JUSTIFY_BIT = 6;
  localparam int unsigned CTL_PIN_OE_BIT = 5;
  localparam int unsigned CTL_PSS_LSB = 2;
  localparam int unsigned CTL_PSS_MSB = 3;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hEC;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [8:0] LADDER_RESET = 9'h000;

  // status register fields
  localparam int unsigned STAT_ENABLE_BIT = 15;
  localparam int unsigned STAT_PIN_BIT = 14;

  // code register layouts per justification
  localparam logic [7:0] LEFT_HIGH_MASK = 8'hFF;
  localparam logic [7:0] LEFT_LOW_MASK = 8'h80;
  localparam logic [7:0] RIGHT_HIGH_MASK = 8'h01;
  localparam logic [7:0] RIGHT_LOW_MASK = 8'hFF;

  typedef enum logic [1:0] {
    RLC_SRC_SUPPLY,
    RLC_SRC_OPAMP,
    RLC_SRC_EXTREF,
    RLC_SRC_FIXED
  } rlc_source_t;

  function automatic logic [7:0] rlc_high_mask(input logic right_just);
    return right_just ? RIGHT_HIGH_MASK : LEFT_HIGH_MASK;
  endfunction

  function automatic logic [7:0] rlc_low_mask(input logic right_just);
    return right_just ? RIGHT_LOW_MASK : LEFT_LOW_MASK;
  endfunction

  // folds the register pair into the 9-bit ladder code
  function automatic logic [8:0] rlc_assemble(input logic right_just,
                                               input logic [7:0] high,
                                               input logic [7:0] low);
    if (right_just) begin
      return {high[0], low};
    end
    return {high, low[7]};
  endfunction

endpackage

// ---- hdl/rlc_top.sv ----
// Notes on behaviour
// - With the pin output enable set, the pin's digital driver and input detector are cut off.
// - While the pin carries the reference, reading its port bit gives zero.
// - The code pair enters the active buffer only when the high register is written.
// - Control bit 7 turns the ladder on when set and off when cleared.
// - Control bit 6 picks right justification when set, left when cleared.
// - Control bits 3-2 pick the top reference: supply, op-amp, external or fixed.
// - Left layout: high holds code 8..1, low bit 7 holds code 0, rest read zero.
// - Right layout: high bit 0 holds code 8, low holds code 7..0, rest read zero.
// - The ladder gets the buffered code so the level is code times reference over 512.
// - Reset turns the ladder off, frees the pin and clears every control and code bit.
// - Waking from sleep leaves the control register untouched.
// - Unimplemented bits ignore writes and read as zero.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module rlc_top (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sleep state of the core
  input wire logic sleep_active,
  // port logic that shares the output pin
  input wire logic port_out_data,
  input wire logic port_out_en,
  output logic port_read_bit,
  // output pin pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_in_detect_en,
  output logic pad_analog_connect,
  // analog ladder controls
  output logic ladder_enable,
  output logic [8:0] ladder_tap,
  output logic [3:0] source_select_onehot,
  output logic ladder_sleep_warn
);

  // ==========================================================
  // bus decode
  // ==========================================================
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic hit_control;
  logic hit_high;
  logic hit_low;
  logic hit_status;
  logic addr_mapped;
  logic lane0;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // zero wait states: every access phase completes at its first edge
  assign pready = 1'b1;
  assign wr_access = access_phase && pwrite;
  // narrow registers live in lane 0, so writes without it change nothing
  assign lane0 = pstrb[0];

  always_comb begin
    hit_control = 1'b0;
    hit_high = 1'b0;
    hit_low = 1'b0;
    hit_status = 1'b0;
    if (paddr == rlc_pkg::ADDR_CONTROL) begin
      hit_control = 1'b1;
    end else if (paddr == rlc_pkg::ADDR_CODE_HIGH) begin
      hit_high = 1'b1;
    end else if (paddr == rlc_pkg::ADDR_CODE_LOW) begin
      hit_low = 1'b1;
    end else if (paddr == rlc_pkg::ADDR_STATUS) begin
      hit_status = 1'b1;
    end
  end

  assign addr_mapped = hit_control || hit_high || hit_low || hit_status;

  // unmapped addresses and writes to the read-only status word error out
  assign pslverr = access_phase &&
                   (!addr_mapped || (pwrite && hit_status));

  // ==========================================================
  // control register
  // ==========================================================
  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic wr_control;

  assign wr_control = wr_access && hit_control && lane0;
  assign control_nxt = pwdata[7:0] & rlc_pkg::CTL_WRITE_MASK;

  // sleep_active is deliberately absent here: a wake from sleep must
  // find the settings software left behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_r <= rlc_pkg::CTL_RESET;
    end else if (wr_control) begin
      control_r <= control_nxt;
    end
  end

  logic enable_bit;
  logic right_just;
  logic pin_output_enable;
  logic [1:0] positive_source_select;

  assign enable_bit = control_r[rlc_pkg::CTL_ENABLE_BIT];
  assign right_just = control_r[rlc_pkg::CTL_JUSTIFY_BIT];
  assign pin_output_enable = control_r[rlc_pkg::CTL_PIN_OE_BIT];
  assign positive_source_select =
    control_r[rlc_pkg::CTL_PSS_MSB:rlc_pkg::CTL_PSS_LSB];

  // ==========================================================
  // code registers and active buffer
  // ==========================================================
  logic wr_high;
  logic wr_low;
  logic [7:0] code_high_r;
  logic [7:0] code_low_r;
  logic [8:0] ladder_code_r;

  // software is expected to write low then high; a high write alone
  // reuses whatever low half is already held
  assign wr_high = wr_access && hit_high && lane0;
  assign wr_low = wr_access && hit_low && lane0;

  rlc_code_regs rlc_code_regs_inst (
    .pclk(pclk),
    .presetn(presetn),
    .right_just(right_just),
    .wr_high(wr_high),
    .wr_low(wr_low),
    .wdata(pwdata[7:0]),
    .code_high_r(code_high_r),
    .code_low_r(code_low_r),
    .ladder_code_r(ladder_code_r)
  );

  // ==========================================================
  // read path
  // ==========================================================
  logic [31:0] read_value;
  logic [31:0] prdata_r;

  always_comb begin
    read_value = 32'h0000_0000;
    if (hit_control) begin
      read_value[7:0] = control_r & rlc_pkg::CTL_WRITE_MASK;
    end else if (hit_high) begin
      read_value[7:0] = code_high_r &
                        rlc_pkg::rlc_high_mask(right_just);
    end else if (hit_low) begin
      read_value[7:0] = code_low_r &
                        rlc_pkg::rlc_low_mask(right_just);
    end else if (hit_status) begin
      read_value[8:0] = ladder_code_r;
      read_value[rlc_pkg::STAT_ENABLE_BIT] = enable_bit;
      read_value[rlc_pkg::STAT_PIN_BIT] = pin_output_enable;
    end
  end

  // captured in the setup cycle and held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= read_value;
    end
  end

  assign prdata = prdata_r;

  // ==========================================================
  // pin input synchroniser
  // ==========================================================
  logic pad_sync1_r;
  logic pad_sync2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_sync1_r <= 1'b0;
      pad_sync2_r <= 1'b0;
    end else begin
      pad_sync1_r <= pad_in;
      pad_sync2_r <= pad_sync1_r;
    end
  end

  // ==========================================================
  // pin override
  // ==========================================================
  // the analog path wins outright; port logic keeps its own latch but
  // cannot reach the pad until the reference is released
  assign pad_analog_connect = pin_output_enable;
  assign pad_oe = port_out_en && !pin_output_enable;
  assign pad_out = port_out_data && !pin_output_enable;
  assign pad_in_detect_en = !pin_output_enable;
  assign port_read_bit = pin_output_enable ? 1'b0 : pad_sync2_r;

  // ==========================================================
  // ladder drive
  // ==========================================================
  rlc_pkg::rlc_source_t source_sel;

  assign source_sel = rlc_pkg::rlc_source_t'(positive_source_select);

  always_comb begin
    source_select_onehot = 4'h0;
    case (source_sel)
      rlc_pkg::RLC_SRC_FIXED: begin
        source_select_onehot[rlc_pkg::RLC_SRC_FIXED] = 1'b1;
      end
      rlc_pkg::RLC_SRC_EXTREF: begin
        source_select_onehot[rlc_pkg::RLC_SRC_EXTREF] = 1'b1;
      end
      rlc_pkg::RLC_SRC_OPAMP: begin
        source_select_onehot[rlc_pkg::RLC_SRC_OPAMP] = 1'b1;
      end
      default: begin
        source_select_onehot[rlc_pkg::RLC_SRC_SUPPLY] = 1'b1;
      end
    endcase
  end

  // the ladder divides the chosen reference into 512 taps; the tap
  // index is the buffered code itself
  assign ladder_enable = enable_bit;
  assign ladder_tap = ladder_code_r;

  // flags a ladder left running into sleep, where it only wastes current
  assign ladder_sleep_warn = sleep_active && enable_bit;

endmodule
